// ---- scu_pkg.sv ----
// Shared constants for the smart-card UART status and time-out block
package scu_pkg;
   // Register addresses on the multiplexed bus
   localparam logic [3:0] ADDR_TOC = 4'h8;
   localparam logic [3:0] ADDR_TOR_LOW = 4'h9;
   localparam logic [3:0] ADDR_TOR_MID = 4'ha;
   localparam logic [3:0] ADDR_TOR_HIGH = 4'hb;
   localparam logic [3:0] ADDR_POLL_FIFO = 4'hc;
   localparam logic [3:0] ADDR_DATA = 4'hd;
   localparam logic [3:0] ADDR_USR = 4'he;

   // Time-out configuration codes
   localparam logic [7:0] TOC_STOP = 8'h00;
   localparam logic [7:0] TOC_16 = 8'h61;
   localparam logic [7:0] TOC_8AR_16 = 8'h65;
   localparam logic [7:0] TOC_24 = 8'h68;
   localparam logic [7:0] TOC_24_START = 8'h7c;
   localparam logic [7:0] TOC_8AR_16_STOP = 8'he5;

   // uart_status_reg bit positions
   localparam int USR_TO3 = 7;
   localparam int USR_TO1 = 5;
   localparam int USR_EA = 4;
   localparam int USR_PE = 3;
   localparam int USR_OVR = 2;
   localparam int USR_FER = 1;
   localparam int USR_TBE = 0;

   // polling_status bit positions
   localparam int MSR_FE = 6;
   localparam int MSR_BGT = 5;
   localparam int MSR_PR2 = 3;
   localparam int MSR_PR1 = 2;
   localparam int MSR_AUX = 1;
   localparam int MSR_TBE = 0;

   // fifo_control fields
   localparam int FCR_DEPTH_LSB = 0;
   localparam int FCR_PEC_LSB = 4;
   localparam int FIELD_W = 3;

   // ETU counts
   localparam logic [4:0] BGT_ETUS = 5'h16;
   localparam logic [3:0] STOP_ETUS = 4'hc;

   localparam logic [7:0] RST_BYTE = 8'h00;
   // Pin sync reset: {cs_n, ale, rd_n, wr_n, ad[7:0], io, aux, pr1, pr2}
   localparam logic [15:0] PIN_SYNC_RST = 16'hb008;

   typedef enum logic [0:0] {
      TX_IDLE = 1'b0,
      TX_WAIT = 1'b1
   } scu_tx_state_t;
endpackage

// ---- scu_fifo.sv ----
// Receive FIFO with programmable fill limit
`timescale 1ns/1ns
module scu_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic [$clog2(DEPTH):0] limit,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // Ready only below the programmed limit, so a short FIFO fills honestly
   assign in_ready = cnt_q < limit;
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rd_ptr_q];
   assign count = cnt_q;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // DEPTH must be a power of two; pointers wrap naturally
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ---- scu_uart_core.sv ----
// Smart-card UART buffering, status and ETU time-out counter
`timescale 1ns/1ns
module scu_uart_core #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] ad_in,
   output logic [7:0] ad_out,
   output logic ad_oe_n,
   output logic irq_n,
   input wire logic card_io_in,
   output logic card_io_out,
   output logic card_io_oe_n,
   input wire logic aux_irq_pin,
   input wire logic card_one_present,
   input wire logic card_two_present,
   input wire logic uart_soft_reset_n,
   input wire logic sync_card_select,
   input wire logic protocol_t1,
   input wire logic tx_mode,
   input wire logic tbe_irq_disable,
   input wire logic etu_tick,
   input wire logic start_bit,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_parity_err,
   input wire logic frame_err_evt,
   input wire logic early_answer_evt,
   input wire logic tx_nak_evt,
   input wire logic tx_busy,
   input wire logic guard_expired,
   input wire logic tx_done,
   output logic tx_start,
   output logic [7:0] tx_data
);
   localparam int CW = $clog2(FIFO_DEPTH) + 1;

   ////////////////////////////////////////////////////////////////////////////
   // Reset and pin synchronisers
   logic [1:0] rst_sync_q;
   logic rst_n_i;
   logic srst;
   logic [15:0] pin_s1_q;
   logic [15:0] pin_s2_q;
   logic [2:0] edge_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n_i = rst_sync_q[1];
   assign srst = !uart_soft_reset_n;

   always_ff @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_s1_q <= scu_pkg::PIN_SYNC_RST;
         pin_s2_q <= scu_pkg::PIN_SYNC_RST;
         edge_q <= 3'h3;
      end else begin
         pin_s1_q <= {cs_n, ale, rd_n, wr_n, ad_in, card_io_in, aux_irq_pin,
                      card_one_present, card_two_present};
         pin_s2_q <= pin_s1_q;
         edge_q <= pin_s2_q[14:12];
      end
   end

   logic cs_s;
   logic ale_fall;
   logic rd_fall;
   logic rd_rise;
   logic wr_rise;
   logic [7:0] bus_s;
   logic io_s;
   assign cs_s = !pin_s2_q[15];
   assign bus_s = pin_s2_q[11:4];
   assign io_s = pin_s2_q[3];
   assign ale_fall = cs_s && edge_q[2] && !pin_s2_q[14];
   assign rd_fall = cs_s && edge_q[1] && !pin_s2_q[13];
   assign rd_rise = cs_s && !edge_q[1] && pin_s2_q[13];
   assign wr_rise = cs_s && !edge_q[0] && pin_s2_q[12];

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic [3:0] addr_q;
   logic toc_wr;
   logic fcr_wr;
   logic utr_wr;
   logic usr_rd;
   logic urr_rd;

   always_ff @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_q <= 4'h0;
      end else if (ale_fall) begin
         addr_q <= bus_s[3:0];
      end
   end

   // Same address, different register by direction
   assign toc_wr = wr_rise && addr_q == scu_pkg::ADDR_TOC;
   assign fcr_wr = wr_rise && addr_q == scu_pkg::ADDR_POLL_FIFO;
   assign utr_wr = wr_rise && addr_q == scu_pkg::ADDR_DATA;
   assign usr_rd = rd_rise && addr_q == scu_pkg::ADDR_USR;
   assign urr_rd = rd_rise && addr_q == scu_pkg::ADDR_DATA;

   logic [7:0] toc_q;
   logic [7:0] tor_low_q;
   logic [7:0] tor_mid_q;
   logic [7:0] tor_high_q;
   logic [2:0] depth_field_q;
   logic [2:0] pe_limit_q;

   always_ff @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i || srst) begin
         toc_q <= scu_pkg::RST_BYTE;
         tor_low_q <= scu_pkg::RST_BYTE;
         tor_mid_q <= scu_pkg::RST_BYTE;
         tor_high_q <= scu_pkg::RST_BYTE;
         depth_field_q <= 3'h0;
         pe_limit_q <= 3'h0;
      end else if (wr_rise) begin
         case (addr_q)
            scu_pkg::ADDR_TOC: toc_q <= bus_s;
            scu_pkg::ADDR_TOR_LOW: tor_low_q <= bus_s;
            scu_pkg::ADDR_TOR_MID: tor_mid_q <= bus_s;
            scu_pkg::ADDR_TOR_HIGH: tor_high_q <= bus_s;
            scu_pkg::ADDR_POLL_FIFO: begin
               depth_field_q <= bus_s[scu_pkg::FCR_DEPTH_LSB +: scu_pkg::FIELD_W];
               pe_limit_q <= bus_s[scu_pkg::FCR_PEC_LSB +: scu_pkg::FIELD_W];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Time-out counter: section one, sections three+two, or all 24 bits
   logic [7:0] c1_q;
   logic c1_run_q;
   logic c1_arm_q;
   logic c1_stop_mode_q;
   logic [3:0] c1_etu_q;
   logic [15:0] c23_q;
   logic c23_run_q;
   logic [23:0] c24_q;
   logic c24_run_q;
   logic c24_restart_q;
   logic c1_tc;
   logic c23_tc;
   logic c24_tc;

   // Counts are ETUs; value N ends on the Nth tick
   assign c1_tc = c1_run_q && etu_tick && c1_q <= 8'h01;
   assign c23_tc = c23_run_q && etu_tick && c23_q <= 16'h0001;
   assign c24_tc = c24_run_q && etu_tick && c24_q <= 24'h000001;

   always_ff @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i || srst) begin
         c1_q <= 8'h00;
         c1_run_q <= 1'b0;
         c1_arm_q <= 1'b0;
         c1_stop_mode_q <= 1'b0;
         c1_etu_q <= 4'h0;
         c23_q <= 16'h0000;
         c23_run_q <= 1'b0;
         c24_q <= 24'h000000;
         c24_run_q <= 1'b0;
         c24_restart_q <= 1'b0;
      end else if (toc_wr) begin
         c1_run_q <= 1'b0;
         c1_arm_q <= 1'b0;
         c23_run_q <= 1'b0;
         c24_run_q <= 1'b0;
         c24_restart_q <= 1'b0;
         c1_stop_mode_q <= bus_s == scu_pkg::TOC_8AR_16_STOP;
         case (bus_s)
            scu_pkg::TOC_STOP: ;
            scu_pkg::TOC_16: begin
               c23_q <= {tor_high_q, tor_mid_q};
               c23_run_q <= 1'b1;
            end
            scu_pkg::TOC_8AR_16, scu_pkg::TOC_8AR_16_STOP: begin
               c23_q <= {tor_high_q, tor_mid_q};
               c23_run_q <= 1'b1;
               c1_arm_q <= 1'b1;
            end
            scu_pkg::TOC_24: begin
               c24_q <= {tor_high_q, tor_mid_q, tor_low_q};
               c24_run_q <= 1'b1;
            end
            scu_pkg::TOC_24_START: c24_restart_q <= 1'b1;
            // Undefined codes leave everything stopped
            default: ;
         endcase
      end else begin
         if (c1_arm_q && start_bit) begin
            c1_q <= tor_low_q;
            c1_run_q <= 1'b1;
            c1_arm_q <= 1'b0;
            c1_etu_q <= 4'h0;
         end else if (c1_run_q && etu_tick) begin
            c1_etu_q <= c1_etu_q + 1'b1;
            if (c1_stop_mode_q && c1_etu_q == scu_pkg::STOP_ETUS - 1'b1) begin
               c1_run_q <= 1'b0;
            end
            if (c1_tc) begin
               c1_q <= tor_low_q;
            end else begin
               c1_q <= c1_q - 1'b1;
            end
         end
         if (c23_tc) begin
            c23_run_q <= 1'b0;
         end else if (c23_run_q && etu_tick) begin
            c23_q <= c23_q - 1'b1;
         end
         // Reload sampled only here, so mid-count writes wait for next start
         if (c24_restart_q && start_bit) begin
            c24_q <= {tor_high_q, tor_mid_q, tor_low_q};
            c24_run_q <= 1'b1;
         end else if (c24_tc) begin
            c24_run_q <= 1'b0;
         end else if (c24_run_q && etu_tick) begin
            c24_q <= c24_q - 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive path and FIFO
   logic fifo_push;
   logic fifo_ready;
   logic fifo_valid;
   logic fifo_pop;
   logic fifo_full;
   logic fifo_full_prev_q;
   logic [7:0] fifo_head;
   logic [CW-1:0] fifo_count;
   logic [CW-1:0] fifo_limit;
   logic t0_bad;

   assign t0_bad = !protocol_t1 && rx_parity_err;
   assign fifo_push = rx_valid && !t0_bad && !sync_card_select;
   assign fifo_limit = CW'(depth_field_q) + 1'b1;
   assign fifo_pop = urr_rd && !sync_card_select;
   assign fifo_full = fifo_count == fifo_limit;

   scu_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk(core_clk),
      .rst_n(rst_n_i),
      .flush(srst),
      .limit(fifo_limit),
      .in_valid(fifo_push),
      .in_ready(fifo_ready),
      .in_data(rx_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_head),
      .count(fifo_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status flags; a set in the clearing cycle wins
   logic to3_q;
   logic to1_q;
   logic ea_q;
   logic pe_q;
   logic ovr_q;
   logic fer_q;
   logic tx_empty_rx_full_q;
   logic tx_mode_q;
   logic [2:0] pe_cnt_q;
   logic pe_done_q;
   logic pe_set;
   logic tbe_set;
   logic tbe_clr;

   assign pe_set = tx_nak_evt || (rx_valid && rx_parity_err && protocol_t1) ||
                   (rx_valid && t0_bad && !pe_done_q && pe_cnt_q == pe_limit_q);
   assign tbe_set = (tx_mode && !tx_mode_q) || tx_done ||
                    (fifo_full && !fifo_full_prev_q);
   assign tbe_clr = utr_wr || fifo_pop || (!tx_mode && tx_mode_q);

   always_ff @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i || srst) begin
         to3_q <= 1'b0;
         to1_q <= 1'b0;
         ea_q <= 1'b0;
         pe_q <= 1'b0;
         ovr_q <= 1'b0;
         fer_q <= 1'b0;
      end else begin
         to3_q <= c23_tc || c24_tc || (to3_q && !usr_rd);
         to1_q <= c1_tc || (to1_q && !usr_rd);
         ea_q <= early_answer_evt || (ea_q && !usr_rd);
         pe_q <= pe_set || (pe_q && !usr_rd);
         ovr_q <= (fifo_push && !fifo_ready) || (ovr_q && !usr_rd);
         fer_q <= frame_err_evt || (fer_q && !usr_rd);
      end
   end

   // Once the limit is hit the counter idles until the limit is rewritten
   always_ff @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i || srst) begin
         pe_cnt_q <= 3'h0;
         pe_done_q <= 1'b0;
      end else if (fcr_wr) begin
         pe_cnt_q <= 3'h0;
         pe_done_q <= 1'b0;
      end else if (rx_valid && !protocol_t1 && !pe_done_q) begin
         if (!rx_parity_err) begin
            pe_cnt_q <= 3'h0;
         end else if (pe_cnt_q == pe_limit_q) begin
            pe_cnt_q <= 3'h0;
            pe_done_q <= 1'b1;
         end else begin
            pe_cnt_q <= pe_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i || srst) begin
         tx_empty_rx_full_q <= 1'b0;
         tx_mode_q <= 1'b0;
         fifo_full_prev_q <= 1'b0;
      end else begin
         tx_empty_rx_full_q <= tbe_set || (tx_empty_rx_full_q && !tbe_clr);
         tx_mode_q <= tx_mode;
         fifo_full_prev_q <= fifo_full;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Block guard counter
   logic [4:0] bgt_cnt_q;
   logic bgt_run_q;
   logic bgt_q;

   always_ff @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i || srst) begin
         bgt_cnt_q <= 5'h00;
         bgt_run_q <= 1'b0;
         bgt_q <= 1'b0;
      end else if (start_bit) begin
         bgt_cnt_q <= 5'h00;
         bgt_run_q <= 1'b1;
         bgt_q <= 1'b0;
      end else if (bgt_run_q && etu_tick) begin
         if (bgt_cnt_q == scu_pkg::BGT_ETUS - 1'b1) begin
            bgt_run_q <= 1'b0;
            bgt_q <= 1'b1;
         end else begin
            bgt_cnt_q <= bgt_cnt_q + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit hand-off
   scu_pkg::scu_tx_state_t tx_state_q;
   logic tx_ok;

   assign tx_ok = !tx_busy && guard_expired;

   always_ff @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i || srst) begin
         tx_state_q <= scu_pkg::TX_IDLE;
         tx_start <= 1'b0;
         tx_data <= scu_pkg::RST_BYTE;
      end else begin
         tx_start <= 1'b0;
         if (utr_wr) begin
            tx_data <= bus_s;
         end
         case (tx_state_q)
            scu_pkg::TX_IDLE: begin
               if (utr_wr && !sync_card_select) begin
                  if (tx_ok) begin
                     tx_start <= 1'b1;
                  end else begin
                     tx_state_q <= scu_pkg::TX_WAIT;
                  end
               end
            end
            scu_pkg::TX_WAIT: begin
               // Sync mode owns the I/O line, so a queued character waits
               if (tx_ok && !sync_card_select) begin
                  tx_start <= 1'b1;
                  tx_state_q <= scu_pkg::TX_IDLE;
               end
            end
            default: tx_state_q <= scu_pkg::TX_IDLE;
         endcase
      end
   end

   // Synchronous cards bypass the character engine
   always_ff @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         card_io_out <= 1'b1;
         card_io_oe_n <= 1'b1;
      end else begin
         card_io_out <= tx_data[0];
         card_io_oe_n <= !sync_card_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux, bus drive and interrupt
   logic [7:0] usr_val;
   logic [7:0] msr_val;
   logic [7:0] rd_mux;

   always_comb begin
      usr_val = 8'h00;
      usr_val[scu_pkg::USR_TO3] = to3_q;
      usr_val[scu_pkg::USR_TO1] = to1_q;
      usr_val[scu_pkg::USR_EA] = ea_q;
      usr_val[scu_pkg::USR_PE] = pe_q;
      usr_val[scu_pkg::USR_OVR] = ovr_q;
      usr_val[scu_pkg::USR_FER] = fer_q;
      usr_val[scu_pkg::USR_TBE] = tx_empty_rx_full_q;
      msr_val = 8'h00;
      msr_val[scu_pkg::MSR_FE] = !fifo_valid;
      msr_val[scu_pkg::MSR_BGT] = bgt_q;
      msr_val[scu_pkg::MSR_PR2] = pin_s2_q[0];
      msr_val[scu_pkg::MSR_PR1] = pin_s2_q[1];
      msr_val[scu_pkg::MSR_AUX] = pin_s2_q[2];
      msr_val[scu_pkg::MSR_TBE] = tx_empty_rx_full_q;
      case (addr_q)
         scu_pkg::ADDR_TOC: rd_mux = toc_q;
         scu_pkg::ADDR_POLL_FIFO: rd_mux = msr_val;
         scu_pkg::ADDR_DATA: rd_mux = sync_card_select ? {7'h00, io_s} : fifo_head;
         scu_pkg::ADDR_USR: rd_mux = usr_val;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ad_out <= 8'h00;
         ad_oe_n <= 1'b1;
         irq_n <= 1'b1;
      end else begin
         if (rd_fall) begin
            ad_out <= rd_mux;
            ad_oe_n <= 1'b0;
         end else if (!cs_s || pin_s2_q[13]) begin
            ad_oe_n <= 1'b1;
         end
         // Polling bits stay off the interrupt; receive-full only at fill
         irq_n <= !(to3_q || to1_q || ea_q || pe_q || ovr_q || fer_q ||
                    (tx_empty_rx_full_q && !tbe_irq_disable));
      end
   end
endmodule

// ---- scu_uart_core_asserts.sv ----
// Port-level checks for the smart-card UART core
`timescale 1ns/1ns
module scu_uart_core_asserts #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic ad_oe_n,
   input wire logic irq_n,
   input wire logic card_io_oe_n,
   input wire logic sync_card_select,
   input wire logic uart_soft_reset_n,
   input wire logic protocol_t1,
   input wire logic rx_valid,
   input wire logic rx_parity_err,
   input wire logic tx_nak_evt,
   input wire logic tx_busy,
   input wire logic guard_expired,
   input wire logic tx_start
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_irq_soon;
      ##[1:3] !irq_n;
   endsequence
   sequence s_soft_held;
      !uart_soft_reset_n [*2];
   endsequence
   a_start_pulse: assert property (tx_start |=> !tx_start)
      else $error("start pulse too long");
   a_start_cause: assert property (tx_start |-> !$past(tx_busy) && $past(guard_expired))
      else $error("start while busy or in guard");
   a_sync_quiet: assert property ($past(sync_card_select) |-> !tx_start)
      else $error("start in sync mode");
   a_io_enable: assert property ($past(rstn, 4) |-> card_io_oe_n == !$past(sync_card_select))
      else $error("io enable wrong");
   a_read_window: assert property (!ad_oe_n |-> !$past(rd_n, 3) && !$past(cs_n, 3))
      else $error("bus driven outside read");
   a_nak_irq: assert property (tx_nak_evt && uart_soft_reset_n |-> s_irq_soon)
      else $error("nak gave no interrupt");
   a_t1_parity: assert property (protocol_t1 && rx_valid && rx_parity_err
         && uart_soft_reset_n |-> s_irq_soon)
      else $error("parity gave no interrupt");
   a_soft_clear: assert property (s_soft_held |=> irq_n)
      else $error("interrupt kept through clear");
endmodule
bind scu_uart_core scu_uart_core_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.*);

// ---- scu_card_model.sv ----
// Card side: shared I/O line and character timing
`timescale 1ns/1ns
module scu_card_model (
   input wire logic core_clk,
   input wire logic tx_start,
   input wire logic card_io_out,
   input wire logic card_io_oe_n,
   input wire logic [5:0] char_len,
   output logic tx_busy,
   output logic tx_done = 1'b0,
   output logic card_io_in
);
   logic [5:0] left_q = 6'h00;
   // Pull-up wins once the block lets go
   assign card_io_in = card_io_oe_n ? 1'b1 : card_io_out;
   assign tx_busy = left_q != 6'h00;
   always @(posedge core_clk) begin
      tx_done <= left_q == 6'h01;
      if (tx_start) begin
         left_q <= char_len;
      end else if (tx_busy) begin
         left_q <= left_q - 6'h01;
      end
   end
endmodule

// ---- scu_tb.sv ----
// Self-checking bench for the smart-card UART core
`timescale 1ns/1ns
module testbench;
   logic core_clk = 1'b0, rstn = 1'b0, cs_n = 1'b1, ale = 1'b0, rd_n = 1'b1, wr_n = 1'b1;
   logic aux_irq_pin = 1'b1, card_one_present = 1'b1, card_two_present = 1'b0;
   logic uart_soft_reset_n = 1'b1, sync_card_select = 1'b0, protocol_t1 = 1'b0;
   logic tx_mode = 1'b0, tbe_irq_disable = 1'b0, frame_err_evt = 1'b0, early_answer_evt = 1'b0;
   logic etu_tick = 1'b0, start_bit = 1'b0, rx_valid = 1'b0, rx_parity_err = 1'b0;
   logic tx_nak_evt = 1'b0, guard_expired = 1'b1, ad_oe_n, irq_n, card_io_in, card_io_out;
   logic card_io_oe_n, tx_busy, tx_done, tx_start;
   logic [7:0] ad_in = 8'h00, rx_data = 8'h00, ad_out, tx_data, rv;
   logic [5:0] clen = 6'h06;
   int n_fail = 0, n_tests = 0, n_start = 0;
   scu_uart_core uut (.*);
   scu_card_model card (.core_clk, .tx_start, .card_io_out, .card_io_oe_n, .char_len(clen),
      .tx_busy, .tx_done, .card_io_in);
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (tx_start === 1'b1) n_start++;
   end
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // ALE phases kept at four cycles, read/write strobes at five: pins pass a two-flop sync
   task bus(input logic [3:0] a, input logic [7:0] d, input logic wr);
      cs_n = 1'b0;
      ad_in = {4'h0, a};
      ale = 1'b1;
      cyc(4);
      ale = 1'b0;
      cyc(4);
      ad_in = d;
      wr_n = !wr;
      rd_n = wr;
      cyc(5);
      rv = ad_out;
      wr_n = 1'b1;
      rd_n = 1'b1;
      cyc(5);
      cs_n = 1'b1;
      cyc(3);
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e, input string nm);
      bus(a, 8'h00, 1'b0);
      chk(nm, rv, e);
   endtask
   task push(input logic [7:0] d, input logic pe);
      rx_valid = 1'b1;
      rx_data = d;
      rx_parity_err = pe;
      cyc(1);
      rx_valid = 1'b0;
      rx_parity_err = 1'b0;
      cyc(3);
   endtask
   task pulse(input logic tick);
      etu_tick = tick;
      start_bit = !tick;
      cyc(1);
      etu_tick = 1'b0;
      start_bit = 1'b0;
      cyc(1);
   endtask
   task t_fifo;
      rd(4'hc, 8'h46, "poll reset");
      rd(4'hf, 8'h00, "unmapped");
      bus(4'hc, 8'h01, 1'b1);
      push(8'h11, 1'b0);
      chk("irq half", {7'h0, irq_n}, 8'h01);
      push(8'h22, 1'b0);
      chk("irq full", {7'h0, irq_n}, 8'h00);
      rd(4'hc, 8'h07, "poll full");
      rd(4'hd, 8'h11, "head");
      chk("irq read", {7'h0, irq_n}, 8'h01);
      rd(4'hd, 8'h22, "second");
      push(8'h33, 1'b0);
      aux_irq_pin = 1'b0;
      card_two_present = 1'b1;
      uart_soft_reset_n = 1'b0;
      cyc(2);
      uart_soft_reset_n = 1'b1;
      rd(4'hc, 8'h4c, "poll cleared");
      push(8'h44, 1'b0);
      chk("irq depth one", {7'h0, irq_n}, 8'h00);
      rd(4'hd, 8'h44, "single");
   endtask
   task t_parity;
      bus(4'hc, 8'h17, 1'b1);
      push(8'he1, 1'b1);
      push(8'h5a, 1'b0);
      push(8'he2, 1'b1);
      chk("irq one err", {7'h0, irq_n}, 8'h01);
      push(8'he3, 1'b1);
      rd(4'he, 8'h08, "pe limit");
      rd(4'he, 8'h00, "pe cleared");
      bus(4'hc, 8'h17, 1'b1);
      rd(4'hd, 8'h5a, "kept byte");
      rd(4'hc, 8'h4c, "dropped");
      protocol_t1 = 1'b1;
      push(8'hc3, 1'b1);
      rd(4'he, 8'h08, "pe t1");
      rd(4'hd, 8'hc3, "t1 byte");
      protocol_t1 = 1'b0;
      tx_nak_evt = 1'b1;
      cyc(1);
      tx_nak_evt = 1'b0;
      rd(4'he, 8'h08, "nak");
      frame_err_evt = 1'b1;
      early_answer_evt = 1'b1;
      cyc(1);
      frame_err_evt = 1'b0;
      early_answer_evt = 1'b0;
      rd(4'he, 8'h12, "fer ea");
      rd(4'he, 8'h00, "fer ea cleared");
   endtask
   task to_run(input logic [7:0] c, lo, mid, input logic st, input int n, input logic [7:0] e);
      bus(4'h9, lo, 1'b1);
      bus(4'ha, mid, 1'b1);
      bus(4'hb, 8'h00, 1'b1);
      bus(4'h8, c, 1'b1);
      rd(4'h8, c, "config");
      if (st) pulse(1'b0);
      repeat (n - 1) pulse(1'b1);
      chk("irq early", {7'h0, irq_n}, 8'h01);
      pulse(1'b1);
      cyc(2);
      chk("irq end", {7'h0, irq_n}, {7'h0, e == 8'h00});
      rd(4'he, e, "timeout");
      bus(4'h8, 8'h00, 1'b1);
   endtask
   task t_timeout;
      to_run(8'h61, 8'h05, 8'h03, 1'b0, 3, 8'h80);
      to_run(8'h65, 8'h02, 8'h09, 1'b1, 2, 8'h20);
      to_run(8'he5, 8'h02, 8'h09, 1'b1, 2, 8'h20);
      // Section one must fall silent after the twelfth ETU
      bus(4'h8, 8'he5, 1'b1);
      pulse(1'b0);
      repeat (12) pulse(1'b1);
      rd(4'he, 8'ha0, "stop twelve");
      repeat (4) pulse(1'b1);
      rd(4'he, 8'h00, "stopped");
      bus(4'h8, 8'h00, 1'b1);
      to_run(8'h68, 8'h02, 8'h00, 1'b0, 2, 8'h80);
      to_run(8'h7c, 8'h04, 8'h00, 1'b1, 4, 8'h80);
      to_run(8'h00, 8'h02, 8'h00, 1'b1, 3, 8'h00);
      pulse(1'b0);
      repeat (21) pulse(1'b1);
      rd(4'hc, 8'h4c, "guard early");
      pulse(1'b1);
      rd(4'hc, 8'h6c, "guard done");
   endtask
   task t_tx;
      sync_card_select = 1'b1;
      bus(4'hd, 8'hfe, 1'b1);
      chk("io", {7'h0, card_io_out}, 8'h00);
      rd(4'hd, 8'h00, "io mirror");
      bus(4'hd, 8'h01, 1'b1);
      chk("io high", {7'h0, card_io_out}, 8'h01);
      rd(4'hd, 8'h01, "io mirror high");
      sync_card_select = 1'b0;
      guard_expired = 1'b0;
      bus(4'hd, 8'h3c, 1'b1);
      chk("guard hold", n_start[7:0], 8'h00);
      guard_expired = 1'b1;
      cyc(10);
      chk("tx data", tx_data, 8'h3c);
      clen = 6'h28;
      bus(4'hd, 8'ha5, 1'b1);
      bus(4'hd, 8'h5a, 1'b1);
      chk("no overlap", n_start[7:0], 8'h02);
      cyc(40);
      chk("queued", n_start[7:0], 8'h03);
      rd(4'he, 8'h01, "sent");
      tx_mode = 1'b1;
      cyc(1);
      tx_mode = 1'b0;
      rd(4'hc, 8'h6c, "receive mode");
      tbe_irq_disable = 1'b1;
      tx_mode = 1'b1;
      rd(4'hc, 8'h6d, "transmit mode");
      chk("irq masked", {7'h0, irq_n}, 8'h01);
      tbe_irq_disable = 1'b0;
      cyc(2);
      chk("irq unmasked", {7'h0, irq_n}, 8'h00);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      cyc(5);
      rstn = 1'b1;
      cyc(10);
      t_fifo;
      t_parity;
      t_timeout;
      t_tx;
      wrap_up;
   end
   // Run needs about 1900 cycles; limit is roughly thirteen times that
   initial begin
      #100000;
      n_fail++;
      wrap_up;
   end
endmodule
